// [core/sev_pkg.sv]
// Shared constants for the serial word-EEPROM link: both ends include them.
// Assumes one 100 MHz system clock and a serial clock made by the host end.
package sev_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int CMD_BITS = 1 + 2 + ADDR_W;
  localparam int FIFO_DEPTH = 32;
  // Opcodes and sub-opcodes carried in the top address bits
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] SUB_EN = 2'h3;
  localparam logic [1:0] SUB_DIS = 2'h0;
  localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // Timing, each time in its own unit and its cycle count beside it
  localparam int CLK_NS = 10;
  localparam int T_WRITE_US = 2000;
  localparam int T_ERASE_US = 1000;
  localparam int T_ALL_US = 15000;
  localparam int T_CSL_NS = 100;
  localparam int WRITE_CYC = T_WRITE_US * 1000 / CLK_NS;
  localparam int ERASE_CYC = T_ERASE_US * 1000 / CLK_NS;
  localparam int ALL_CYC = T_ALL_US * 1000 / CLK_NS;
  localparam int CSL_CYC = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 21;
  localparam int SCLK_HALF = 5;
  localparam int POLL_WAIT = 4;
  typedef enum logic [2:0]
  {
    SEV_CMD_READ = 3'h0,
    SEV_CMD_WRITE = 3'h1,
    SEV_CMD_ERASE = 3'h2,
    SEV_CMD_EN = 3'h3,
    SEV_CMD_DIS = 3'h4,
    SEV_CMD_ERASE_ALL_CMD = 3'h5,
    SEV_CMD_WRITE_ALL_CMD = 3'h6
  } sev_cmd_e;
endpackage

// [core/sev_link_if.sv]
// Serial link between host controller and EEPROM end.
// Data out stands for a three-state pin: the host end reads sdo_oe beside it.
`timescale 1ns/10ps
`default_nettype none
interface sev_link_if;
  logic cs;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport device (input cs, input sclk, input sdi, output sdo, output sdo_oe);
  modport host (output cs, output sclk, output sdi, input sdo, input sdo_oe);
endinterface
`default_nettype wire

// [core/sev_device.sv]
// EEPROM end: instruction decode, word array, self-timed programming.
// Assumes link inputs are synchronous to mclk and the serial clock is slower.
`timescale 1ns/10ps
`default_nettype none
module sev_device #(
  parameter int ADDR_W = sev_pkg::ADDR_W,
  parameter int DATA_W = sev_pkg::DATA_W,
  parameter int WRITE_CYCLES = sev_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = sev_pkg::ERASE_CYC,
  parameter int ALL_CYCLES = sev_pkg::ALL_CYC
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  sev_link_if.device link,
  output logic busy,
  output logic prog_en
);
  typedef enum logic [2:0]
  {
    SEV_IDLE = 3'h0,
    SEV_OPC = 3'h1,
    SEV_ADDR = 3'h2,
    SEV_DATA = 3'h3,
    SEV_READ = 3'h4,
    SEV_DONE = 3'h5
  } sev_dev_st_e;
  typedef enum logic [1:0]
  {
    SEV_K_WORD_WR = 2'h0,
    SEV_K_WORD_ER = 2'h1,
    SEV_K_ALL_ER = 2'h2,
    SEV_K_ALL_WR = 2'h3
  } sev_kind_e;

  sev_dev_st_e state;
  sev_kind_e kind;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic sclk_q;
  logic cs_q;
  logic [4:0] bcnt;
  logic [1:0] opc;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] p_addr;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] p_data;
  logic [DATA_W-1:0] rd_sh;
  logic [sev_pkg::TMR_W-1:0] tmr;
  logic armed;
  logic status_show;
  logic rise;
  logic last_addr;
  logic last_data;
  logic [ADDR_W-1:0] full_addr;
  logic [1:0] sub;
  logic can_prog;
  logic go_write;
  logic go_write_all_cmd;
  logic go_erase;
  logic go_erase_all_cmd;
  logic go_prog;
  logic finish;

  // Edge of the host serial clock, seen in the mclk domain
  assign rise = link.sclk & ~sclk_q & link.cs;
  assign last_addr = rise && state == SEV_ADDR && bcnt == 5'(ADDR_W - 1);
  assign last_data = rise && state == SEV_DATA && bcnt == 5'(DATA_W - 1);
  assign full_addr = {addr[ADDR_W-2:0], link.sdi};
  assign sub = full_addr[ADDR_W-1 -: 2];
  // New cycles are refused while one runs, so the timer is never re-armed
  assign can_prog = prog_en & ~busy;
  assign go_write = last_data && opc == sev_pkg::OP_WRITE && can_prog;
  assign go_write_all_cmd = last_data && opc == sev_pkg::OP_EXT && can_prog;
  assign go_erase = last_addr && opc == sev_pkg::OP_ERASE && can_prog;
  assign go_erase_all_cmd = last_addr && opc == sev_pkg::OP_EXT && sub == sev_pkg::SUB_ERASE_ALL_CMD && can_prog;
  assign go_prog = go_write | go_write_all_cmd | go_erase | go_erase_all_cmd;
  assign finish = busy && tmr == sev_pkg::TMR_W'(1);

  // Edge history of serial clock and chip select
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'b0;
      cs_q <= 1'b0;
    end
    else if (ce)
    begin
      sclk_q <= link.sclk;
      cs_q <= link.cs;
    end
  end

  // Instruction sequencer; deselect returns it to waiting for a start bit
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= SEV_IDLE;
      bcnt <= 5'h00;
      opc <= 2'h0;
      addr <= '0;
      shreg <= '0;
    end
    else if (ce)
    begin
      if (!link.cs)
      begin
        state <= SEV_IDLE;
        bcnt <= 5'h00;
      end
      else if (rise)
      begin
        unique case (state)
          SEV_IDLE:
          begin
            if (link.sdi)
            begin
              state <= SEV_OPC;
              bcnt <= 5'h00;
            end
          end
          SEV_OPC:
          begin
            opc <= {opc[0], link.sdi};
            bcnt <= (bcnt == 5'h01) ? 5'h00 : bcnt + 5'h01;
            if (bcnt == 5'h01)
            begin
              state <= SEV_ADDR;
            end
          end
          SEV_ADDR:
          begin
            addr <= full_addr;
            bcnt <= last_addr ? 5'h00 : bcnt + 5'h01;
            if (last_addr)
            begin
              if (opc == sev_pkg::OP_READ)
              begin
                state <= SEV_READ;
              end
              else if (opc == sev_pkg::OP_WRITE || (opc == sev_pkg::OP_EXT && sub == sev_pkg::SUB_WRITE_ALL_CMD))
              begin
                state <= SEV_DATA;
              end
              else
              begin
                state <= SEV_DONE;
              end
            end
          end
          SEV_DATA:
          begin
            shreg <= {shreg[DATA_W-2:0], link.sdi};
            bcnt <= bcnt + 5'h01;
            if (last_data)
            begin
              state <= SEV_DONE;
            end
          end
          SEV_READ:
          begin
            if (bcnt == 5'(DATA_W))
            begin
              state <= SEV_DONE;
            end
            else
            begin
              bcnt <= bcnt + 5'h01;
            end
          end
          SEV_DONE:
          begin
            state <= SEV_DONE;
          end
          default:
          begin
            state <= SEV_IDLE;
          end
        endcase
      end
    end
  end

  // Programming enable latch, off after reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_en <= 1'b0;
    end
    else if (ce && last_addr && opc == sev_pkg::OP_EXT)
    begin
      if (sub == sev_pkg::SUB_EN)
      begin
        prog_en <= 1'b1;
      end
      else if (sub == sev_pkg::SUB_DIS)
      begin
        prog_en <= 1'b0;
      end
    end
  end

  // Self-timed cycle; runs on regardless of chip select
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      tmr <= '0;
      kind <= SEV_K_WORD_WR;
      p_addr <= '0;
      p_data <= '0;
    end
    else if (ce)
    begin
      if (go_prog)
      begin
        busy <= 1'b1;
        p_addr <= go_erase ? full_addr : addr;
        p_data <= {shreg[DATA_W-2:0], link.sdi};
        if (go_write)
        begin
          kind <= SEV_K_WORD_WR;
          tmr <= sev_pkg::TMR_W'(WRITE_CYCLES);
        end
        else if (go_erase)
        begin
          kind <= SEV_K_WORD_ER;
          tmr <= sev_pkg::TMR_W'(ERASE_CYCLES);
        end
        else
        begin
          kind <= go_erase_all_cmd ? SEV_K_ALL_ER : SEV_K_ALL_WR;
          tmr <= sev_pkg::TMR_W'(ALL_CYCLES);
        end
      end
      else if (busy)
      begin
        tmr <= tmr - sev_pkg::TMR_W'(1);
        busy <= ~finish;
      end
    end
  end

  // Word array: the erase half of a word write lands at once, data at the end
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (go_write)
      begin
        mem[addr] <= sev_pkg::ERASED_WORD;
      end
      if (finish)
      begin
        unique case (kind)
          SEV_K_WORD_WR: mem[p_addr] <= p_data;
          SEV_K_WORD_ER: mem[p_addr] <= sev_pkg::ERASED_WORD;
          SEV_K_ALL_ER:
          begin
            for (int i = 0; i < (1 << ADDR_W); i++)
            begin
              mem[i] <= sev_pkg::ERASED_WORD;
            end
          end
          SEV_K_ALL_WR:
          begin
            for (int i = 0; i < (1 << ADDR_W); i++)
            begin
              mem[i] <= p_data;
            end
          end
        endcase
      end
    end
  end

  // Status is offered only after a reselect following a started cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      armed <= 1'b0;
      status_show <= 1'b0;
    end
    else if (ce)
    begin
      if (go_prog)
      begin
        armed <= 1'b1;
      end
      else if (link.cs && !cs_q && armed)
      begin
        armed <= 1'b0;
        status_show <= 1'b1;
      end
      if (!link.cs || (rise && state == SEV_IDLE && link.sdi))
      begin
        status_show <= 1'b0;
      end
    end
  end

  // Data out driver; one mclk after the sampling edge stands for output_delay
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.sdo <= 1'b0;
      link.sdo_oe <= 1'b0;
      rd_sh <= '0;
    end
    else if (ce)
    begin
      if (!link.cs)
      begin
        link.sdo_oe <= 1'b0;
      end
      else if (last_addr && opc == sev_pkg::OP_READ)
      begin
        link.sdo_oe <= 1'b1;
        link.sdo <= 1'b0;
        rd_sh <= mem[full_addr];
      end
      else if (state == SEV_READ)
      begin
        // Updates only on rising edges, so a paused clock holds the bit
        if (rise && bcnt != 5'(DATA_W))
        begin
          link.sdo <= rd_sh[DATA_W-1];
          rd_sh <= {rd_sh[DATA_W-2:0], 1'b0};
        end
        else if (rise)
        begin
          link.sdo_oe <= 1'b0;
        end
      end
      else if (status_show)
      begin
        link.sdo_oe <= 1'b1;
        link.sdo <= ~busy;
      end
      else
      begin
        link.sdo_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [core/sev_host.sv]
// Host end: turns user commands into serial frames, buffers read words.
// Assumes the EEPROM end shares mclk; the serial clock is divided from it.
`timescale 1ns/10ps
`default_nettype none
module sev_fifo #(
  parameter int W = sev_pkg::DATA_W,
  parameter int DEPTH = sev_pkg::FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign next_count = count + CW'(push) - CW'(pop);
  assign out_data = store[rd_ptr];

  // Pointers and registered full/empty flags
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else if (ce)
    begin
      wr_ptr <= push ? PW'((int'(wr_ptr) + 1) % DEPTH) : wr_ptr;
      rd_ptr <= pop ? PW'((int'(rd_ptr) + 1) % DEPTH) : rd_ptr;
      count <= next_count;
      in_ready <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ce && push)
    begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

module sev_host #(
  parameter int ADDR_W = sev_pkg::ADDR_W,
  parameter int DATA_W = sev_pkg::DATA_W,
  parameter int HALF = sev_pkg::SCLK_HALF
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  sev_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sev_pkg::sev_cmd_e cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data
);
  localparam int TXW = 3 + ADDR_W + DATA_W;
  typedef enum logic [2:0]
  {
    SEV_H_IDLE = 3'h0,
    SEV_H_SHIFT = 3'h1,
    SEV_H_GAP = 3'h2,
    SEV_H_POLL = 3'h3,
    SEV_H_PUSH = 3'h4,
    SEV_H_REST = 3'h5
  } sev_host_st_e;

  sev_host_st_e state;
  logic [TXW-1:0] tx;
  logic [TXW-1:0] next_tx;
  logic [DATA_W-1:0] rx;
  logic [4:0] nclk;
  logic [4:0] rcnt;
  logic [7:0] div;
  logic [7:0] wait_cnt;
  logic is_read;
  logic is_prog;
  logic push_v;
  logic fifo_ready;
  logic accept;

  assign accept = cmd_valid & cmd_ready;

  // Frame image: start bit, opcode, address or sub-opcode, optional data
  always_comb
  begin
    next_tx = '0;
    unique case (cmd_op)
      sev_pkg::SEV_CMD_READ: next_tx = {1'b1, sev_pkg::OP_READ, cmd_addr, DATA_W'(0)};
      sev_pkg::SEV_CMD_WRITE: next_tx = {1'b1, sev_pkg::OP_WRITE, cmd_addr, cmd_data};
      sev_pkg::SEV_CMD_ERASE: next_tx = {1'b1, sev_pkg::OP_ERASE, cmd_addr, DATA_W'(0)};
      sev_pkg::SEV_CMD_EN: next_tx = {1'b1, sev_pkg::OP_EXT, sev_pkg::SUB_EN, (ADDR_W+DATA_W-2)'(0)};
      sev_pkg::SEV_CMD_DIS: next_tx = {1'b1, sev_pkg::OP_EXT, sev_pkg::SUB_DIS, (ADDR_W+DATA_W-2)'(0)};
      sev_pkg::SEV_CMD_ERASE_ALL_CMD: next_tx = {1'b1, sev_pkg::OP_EXT, sev_pkg::SUB_ERASE_ALL_CMD, (ADDR_W+DATA_W-2)'(0)};
      sev_pkg::SEV_CMD_WRITE_ALL_CMD: next_tx = {1'b1, sev_pkg::OP_EXT, sev_pkg::SUB_WRITE_ALL_CMD, (ADDR_W-2)'(0), cmd_data};
      default: next_tx = '0;
    endcase
  end

  // Frame sequencer; data changes on falling edges, sampled on falling too
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= SEV_H_IDLE;
      link.cs <= 1'b0;
      link.sclk <= 1'b0;
      link.sdi <= 1'b0;
      cmd_ready <= 1'b1;
      tx <= '0;
      rx <= '0;
      nclk <= 5'h00;
      rcnt <= 5'h00;
      div <= 8'h00;
      wait_cnt <= 8'h00;
      is_read <= 1'b0;
      is_prog <= 1'b0;
      push_v <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state)
        SEV_H_IDLE:
        begin
          if (accept)
          begin
            cmd_ready <= 1'b0;
            link.cs <= 1'b1;
            link.sdi <= next_tx[TXW-1];
            tx <= {next_tx[TXW-2:0], 1'b0};
            is_read <= cmd_op == sev_pkg::SEV_CMD_READ;
            is_prog <= cmd_op == sev_pkg::SEV_CMD_WRITE || cmd_op == sev_pkg::SEV_CMD_ERASE
              || cmd_op == sev_pkg::SEV_CMD_ERASE_ALL_CMD || cmd_op == sev_pkg::SEV_CMD_WRITE_ALL_CMD;
            nclk <= (cmd_op == sev_pkg::SEV_CMD_READ || cmd_op == sev_pkg::SEV_CMD_WRITE
              || cmd_op == sev_pkg::SEV_CMD_WRITE_ALL_CMD) ? 5'(sev_pkg::CMD_BITS + DATA_W) : 5'(sev_pkg::CMD_BITS);
            rcnt <= 5'h00;
            div <= 8'h00;
            state <= SEV_H_SHIFT;
          end
        end
        SEV_H_SHIFT:
        begin
          div <= (div == 8'(HALF - 1)) ? 8'h00 : div + 8'h01;
          if (div == 8'(HALF - 1))
          begin
            link.sclk <= ~link.sclk;
            if (!link.sclk)
            begin
              rcnt <= rcnt + 5'h01;
            end
            else
            begin
              if (is_read && rcnt > 5'(sev_pkg::CMD_BITS))
              begin
                rx <= {rx[DATA_W-2:0], link.sdo};
              end
              if (rcnt == nclk)
              begin
                link.cs <= 1'b0;
                link.sdi <= 1'b0;
                wait_cnt <= 8'h00;
                state <= is_read ? SEV_H_PUSH : (is_prog ? SEV_H_GAP : SEV_H_REST);
              end
              else
              begin
                // Drives the dummy-bit slot low too, avoiding a clash on a shared wire
                // The last address bit is still sent as is; every slot after it is forced low
                link.sdi <= (is_read && rcnt >= 5'(sev_pkg::CMD_BITS)) ? 1'b0 : tx[TXW-1];
                tx <= {tx[TXW-2:0], 1'b0};
              end
            end
          end
        end
        SEV_H_GAP:
        begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt == 8'(sev_pkg::CSL_CYC - 1))
          begin
            link.cs <= 1'b1;
            wait_cnt <= 8'h00;
            state <= SEV_H_POLL;
          end
        end
        SEV_H_POLL:
        begin
          // Gives up when no status appears, as for an ignored instruction
          wait_cnt <= wait_cnt + 8'h01;
          if ((link.sdo_oe && link.sdo) || (!link.sdo_oe && wait_cnt == 8'(sev_pkg::POLL_WAIT)))
          begin
            link.cs <= 1'b0;
            wait_cnt <= 8'h00;
            state <= SEV_H_REST;
          end
        end
        SEV_H_PUSH:
        begin
          // Stalls here while the read buffer is full
          push_v <= ~(push_v & fifo_ready);
          if (push_v && fifo_ready)
          begin
            state <= SEV_H_REST;
          end
        end
        SEV_H_REST:
        begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt == 8'(sev_pkg::CSL_CYC - 1))
          begin
            cmd_ready <= 1'b1;
            state <= SEV_H_IDLE;
          end
        end
        default:
        begin
          state <= SEV_H_IDLE;
        end
      endcase
    end
  end

  sev_fifo #(.W(DATA_W), .DEPTH(sev_pkg::FIFO_DEPTH)) sev_fifo_inst (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(push_v),
    .in_ready(fifo_ready),
    .in_data(rx),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule
`default_nettype wire

// [bench/sev_link_properties.sv]
// Link checker: serial frames between host end and EEPROM end.
// Takes the link signals and device status as plain inputs; one mclk domain.
`timescale 1ns/10ps
`default_nettype none
module sev_link_properties #(
  parameter int MAX_BUSY = 30
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cs,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic busy,
  input wire logic prog_en
);
  logic sclk_q;
  logic rise;
  logic [4:0] cnt;
  logic [1:0] op;
  logic [15:0] busy_run;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Serial rising edge as the device detects it, one mclk late
  assign rise = sclk & ~sclk_q & cs;
  // Frame bit count and opcode; deselect clears the frame
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'b0;
      cnt <= 5'h0;
      op <= 2'h0;
    end
    else
    begin
      sclk_q <= sclk;
      if (!cs)
        cnt <= 5'h0;
      else if (rise)
        cnt <= cnt + 5'h1;
      if (rise && cnt == 5'h1)
        op[1] <= sdi;
      if (rise && cnt == 5'h2)
        op[0] <= sdi;
    end
  end
  // Length of the current busy stretch, to bound self-timed cycles
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      busy_run <= 16'h0;
    else
      busy_run <= busy ? busy_run + 16'h1 : 16'h0;
  end
  sequence s_read_addr;
    rise && cnt == 5'h8 && op == sev_pkg::OP_READ;
  endsequence
  sequence s_dummy;
    ##[1:3] (sdo_oe && !sdo);
  endsequence
  property p_dummy_zero;
    s_read_addr |-> s_dummy;
  endproperty
  a_dummy_zero: assert property (p_dummy_zero) else $error("no dummy zero after read address");
  property p_erase_start;
    rise && cnt == 5'h8 && op == sev_pkg::OP_ERASE && prog_en && !busy |-> ##[1:3] busy;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start");
  property p_write_start;
    rise && cnt == 5'h18 && op == sev_pkg::OP_WRITE && prog_en && !busy |-> ##[1:3] busy;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write did not start");
  property p_busy_enabled;
    $rose(busy) |-> prog_en;
  endproperty
  a_busy_enabled: assert property (p_busy_enabled) else $error("programming while disabled");
  property p_busy_bound;
    busy_run <= MAX_BUSY + 2;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("self-timed cycle too long");
  property p_release;
    !cs && $past(!cs) |-> !sdo_oe;
  endproperty
  a_release: assert property (p_release) else $error("data out driven while deselected");
  property p_change_high;
    sdo_oe && $past(sdo_oe) && $fell(sdo) |-> sclk;
  endproperty
  a_change_high: assert property (p_change_high) else $error("data out changed with clock low");
  property p_hold;
    sdo_oe && $past(sdo_oe) && !sclk && !$past(sclk) && cnt != 5'h0 |-> $stable(sdo);
  endproperty
  a_hold: assert property (p_hold) else $error("data out moved while clock paused");
  property p_status;
    cs && cnt == 5'h0 && sdo_oe && $past(sdo_oe, 2) && $stable(busy) && busy == $past(busy, 2) |-> sdo == !busy;
  endproperty
  a_status: assert property (p_status) else $error("status does not match busy");
endmodule
`default_nettype wire

// [bench/serial_eeprom_op_modes_bench.sv]
// Bench: host end and EEPROM end joined by the link interface.
// Drives the host command port and judges the words read back.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_op_modes_bench;
  logic mclk;
  logic rst_b;
  logic ce;
  logic cmd_valid;
  logic cmd_ready;
  sev_pkg::sev_cmd_e cmd_op;
  logic [5:0] cmd_addr;
  logic [15:0] cmd_data;
  logic rd_valid;
  logic rd_ready;
  logic [15:0] rd_data;
  logic busy;
  logic prog_en;
  int n_errors = 0;
  int total_checks = 0;
  sev_link_if sev_link_if_inst ();
  // Short self-timed counts keep the run brief
  sev_device #(.WRITE_CYCLES(20), .ERASE_CYCLES(10), .ALL_CYCLES(30)) sev_device_inst (.mclk(mclk), .rst_b(rst_b),
    .ce(ce), .link(sev_link_if_inst.device), .busy(busy), .prog_en(prog_en));
  sev_host sev_host_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce), .link(sev_link_if_inst.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  sev_link_properties #(.MAX_BUSY(30)) sev_link_properties_inst (.mclk(mclk), .rst_b(rst_b),
    .cs(sev_link_if_inst.cs), .sclk(sev_link_if_inst.sclk), .sdi(sev_link_if_inst.sdi), .sdo(sev_link_if_inst.sdo),
    .sdo_oe(sev_link_if_inst.sdo_oe), .busy(busy), .prog_en(prog_en));
  // System clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a flag; a timeout shows up as a mismatch
  task automatic wait_for(input string what, ref logic flag);
    int i;
    i = 0;
    while (flag !== 1'b1 && i < 4000)
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    check(what, 16'h1, {15'h0, flag});
  endtask
  task automatic issue(input sev_pkg::sev_cmd_e op, input logic [5:0] a, input logic [15:0] d);
    wait_for("cmd_ready", cmd_ready);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic run(input sev_pkg::sev_cmd_e op, input logic [5:0] a, input logic [15:0] d);
    issue(op, a, d);
    wait_for("cmd_ready", cmd_ready);
  endtask
  task automatic pop(input logic [15:0] exp);
    wait_for("rd_valid", rd_valid);
    check("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    @(posedge mclk);
    #1;
    rd_ready = 1'b0;
    // Let an edge pass so a following pop never re-raises ready in this time step
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    run(sev_pkg::SEV_CMD_READ, a, 16'h0);
    pop(exp);
  endtask
  // Disabled after reset; writes ignored until enabled again
  task automatic t_protect();
    check("prog_en", 16'h0, {15'h0, prog_en});
    run(sev_pkg::SEV_CMD_EN, 6'h0, 16'h0);
    check("prog_en", 16'h1, {15'h0, prog_en});
    run(sev_pkg::SEV_CMD_ERASE_ALL_CMD, 6'h0, 16'h0);
    run(sev_pkg::SEV_CMD_DIS, 6'h0, 16'h0);
    check("prog_en", 16'h0, {15'h0, prog_en});
    run(sev_pkg::SEV_CMD_WRITE, 6'h3, 16'h1234);
    rd(6'h3, 16'hffff);
    run(sev_pkg::SEV_CMD_EN, 6'h0, 16'h0);
  endtask
  task automatic t_write_all_cmd();
    run(sev_pkg::SEV_CMD_WRITE_ALL_CMD, 6'h0, 16'h5a5a);
    rd(6'h0, 16'h5a5a);
    rd(6'h3f, 16'h5a5a);
  endtask
  // Back-to-back writes; mixed bit patterns expose bit order
  task automatic t_write();
    run(sev_pkg::SEV_CMD_WRITE, 6'h3, 16'ha5c3);
    run(sev_pkg::SEV_CMD_WRITE, 6'h4, 16'h8001);
    rd(6'h3, 16'ha5c3);
    rd(6'h4, 16'h8001);
    rd(6'h5, 16'h5a5a);
  endtask
  task automatic t_erase();
    run(sev_pkg::SEV_CMD_ERASE, 6'h3, 16'h0);
    rd(6'h3, 16'hffff);
    rd(6'h4, 16'h8001);
  endtask
  // Freeze both ends in mid-frame; the read must still come back whole
  task automatic t_freeze();
    issue(sev_pkg::SEV_CMD_READ, 6'h4, 16'h0);
    repeat (60) @(posedge mclk);
    #1;
    ce = 1'b0;
    repeat (50) @(posedge mclk);
    #1;
    check("cmd_ready", 16'h0, {15'h0, cmd_ready});
    ce = 1'b1;
    wait_for("cmd_ready", cmd_ready);
    pop(16'h8001);
  endtask
  // Fill the read buffer until the host stalls, then drain it
  task automatic t_fifo();
    for (int k = 0; k < 33; k++)
      issue(sev_pkg::SEV_CMD_READ, k[0] ? 6'h4 : 6'h3, 16'h0);
    repeat (400) @(posedge mclk);
    #1;
    check("cmd_ready", 16'h0, {15'h0, cmd_ready});
    for (int k = 0; k < 33; k++)
      pop(k[0] ? 16'h8001 : 16'hffff);
    repeat (4) @(posedge mclk);
    #1;
    check("rd_valid", 16'h0, {15'h0, rd_valid});
  endtask
  // Main sequence
  initial
  begin
    ce = 1'b1;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = sev_pkg::SEV_CMD_READ;
    cmd_addr = 6'h0;
    cmd_data = 16'h0;
    rd_ready = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_protect();
    t_write_all_cmd();
    t_write();
    t_erase();
    t_freeze();
    t_fifo();
    summarize();
  end
  // Watchdog: the tests need well under 40000 cycles
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
